// File: pkg/lssel_pkg.sv
// lssel_pkg: register map, field layout and types of the low-speed clock source select
package lssel_pkg;

  // register port widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFF_XTAL_GATE   = 8'hd2;
  localparam logic [7:0] OFF_XTAL_TRIM   = 8'hd3;
  localparam logic [7:0] OFF_OSC_CTRL0   = 8'he0;
  localparam logic [7:0] OFF_XTAL_CFG    = 8'he1;
  localparam logic [7:0] OFF_OSC_CTRL2   = 8'he2;
  localparam logic [7:0] OFF_WDT_RESTART = 8'he3;
  localparam logic [7:0] OFF_SLOW_TRIM   = 8'he9;

  // reset values
  localparam logic [7:0] RST_XTAL_GATE = 8'h07;
  localparam logic [7:0] RST_XTAL_TRIM = 8'h14;
  localparam logic [7:0] RST_OSC_CTRL0 = 8'h00;
  localparam logic [7:0] RST_OSC_CTRL2 = 8'h00;
  localparam logic [7:0] RST_SLOW_TRIM = 8'h18;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;

  // writable bits of each plain register
  localparam logic [7:0] MSK_XTAL_GATE = 8'h07;
  localparam logic [7:0] MSK_XTAL_TRIM = 8'h1f;
  localparam logic [7:0] MSK_OSC_CTRL0 = 8'h98;
  localparam logic [7:0] MSK_OSC_CTRL2 = 8'h14;
  localparam logic [7:0] MSK_SLOW_TRIM = 8'h6f;

  // field positions
  localparam int unsigned BIT_HS_EN    = 4;
  localparam int unsigned BIT_EXT_CLK  = 2;
  localparam int unsigned BIT_PD_STYLE = 6;
  localparam int unsigned BIT_RATE     = 5;
  localparam int unsigned BIT_PRESENT  = 0;
  localparam int unsigned BIT_WRITTEN  = 1;
  localparam int unsigned BIT_LOW_PWR  = 2;
  localparam int unsigned BIT_XTAL_REQ = 7;
  localparam int unsigned TRIM_LSB     = 0;
  localparam int unsigned TRIM_MSB     = 3;
  localparam int unsigned GAIN_LSB     = 2;
  localparam int unsigned GAIN_MSB     = 4;
  localparam int unsigned MODE_LSB     = 0;
  localparam int unsigned MODE_MSB     = 1;
  localparam int unsigned IVL_LSB      = 3;
  localparam int unsigned IVL_MSB      = 4;
  localparam int unsigned GATE_MSB     = 2;

  // crystal enable gate codes and watchdog restart key
  localparam logic [2:0] GATE_ALLOW    = 3'h3;
  localparam logic [2:0] GATE_OFF      = 3'h7;
  localparam logic [7:0] WDT_CLEAR_KEY = 8'h38;

  // sleep timer: 15 bits of 32 kHz ticks, interval masks per select code
  localparam int unsigned SLEEP_W = 15;
  localparam logic [14:0] IVL_MASK_0 = 15'h003f;
  localparam logic [14:0] IVL_MASK_1 = 15'h01ff;
  localparam logic [14:0] IVL_MASK_2 = 15'h0fff;
  localparam logic [14:0] IVL_MASK_1S = 15'h7fff;

  // crystal oscillator power states
  typedef enum logic [1:0] {
    XPWR_DOWN    = 2'b00,
    XPWR_STARTUP = 2'b01,
    XPWR_HIGH    = 2'b10,
    XPWR_LOW     = 2'b11
  } lssel_xpwr_t;

  // controls to the crystal oscillator
  typedef struct packed {
    logic       enable;
    logic [2:0] ampGain;
    logic [1:0] gainMode;
    logic       lowPowerEnable;
  } lssel_xtal_t;

  // controls to the internal slow oscillator
  typedef struct packed {
    logic       enable;
    logic       powerdownStyle;
    logic       rateSelect;
    logic [3:0] trim;
  } lssel_slow_t;

endpackage : lssel_pkg

// File: hdl/lssel_sync3.sv
// lssel_sync3: three-stage input synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module lssel_sync3
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // asynchronous input
  input  wire logic asyncIn,
  // filtered level and its rising edge
  output logic      level,
  output logic      rise
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;
  logic level_q;
  logic rise_q;
  logic agree;

  // a change counts only when stages two and three agree
  assign agree = (stage2_q == stage3_q);

  // shift chain; stage one feeds stage two only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
    end
    else
    begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // filtered level and one-cycle rise pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end
    else
    begin
      level_q <= agree ? stage3_q : level_q;
      rise_q  <= agree & stage3_q & ~level_q;
    end
  end

  assign level = level_q;
  assign rise  = rise_q;

endmodule : lssel_sync3

// File: hdl/lssel_clock_source.sv
// lssel_clock_source: clock source control for system, 48 MHz and 32 kHz clocks
// Notes on behaviour
// - bit 4 gates the 48 MHz clock; debug mode forces it on
// - bit 2 set selects the external clock for the system clock tree
// - on external clock, the debug pin and both oscillator clocks resynchronise to that clock
// - bit 6 picks powerdown style: full shutdown or bias kept alive
// - bit 5 set runs slow oscillator at 1 kHz, else 32 kHz
// - four-bit slow trim loads from factory at boot; software writes can overwrite it
// - after crystal enable, internal source stays until the selected sleep interval edge
// - crystal turned off after switch returns to internal oscillator at once
// - crystal-present flag zero blocks switch-over to the crystal
// - written bit is read-only, set by first configuration write
// - crystal-present flag takes a single write after boot
// - switch-over happens on interval edge without any interrupt enable
// - internal slow oscillator runs until switch-over to the crystal
// - clearing the 32 kHz select bit returns to internal source instantly
// - enable gate resets to 111b (off); 011b lets crystal enable
// - amplifier gain code 000 is highest, 111 lowest
// - gain mode 00 highest power, 11 lowest, default 00
// - configuration bit 2 puts crystal into low-power mode
// - after any reset the internal oscillator is the 32 kHz source
// - crystal has power-down, startup, high-power and low-power states
// - restart register write of 38h clears the sleep timer
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module lssel_clock_source
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // register port
  input  wire logic [7:0]            regAddr,
  input  wire logic [7:0]            regWrData,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output logic [7:0]                 regRdData,
  // factory trim, caught once after reset
  input  wire logic [3:0]            factoryTrim,
  // pins and oscillator outputs
  input  wire logic                  onChipDebugMode,
  input  wire logic                  slowOscClk,
  input  wire logic                  crystalClk,
  // system clock controls
  output logic                       highSpeedClockEnable,
  output logic                       externalClockSelect,
  // oscillator controls
  output lssel_pkg::lssel_slow_t     slowOsc,
  output lssel_pkg::lssel_xtal_t     crystalOsc,
  output lssel_pkg::lssel_xpwr_t     crystalPowerState,
  // 32 kHz source and sleep timer
  output logic                       clk32Select,
  output logic                       sleepIntervalEdge
);

  // masked register update
  function automatic logic [7:0] applyWrite(input logic [7:0] old,
                                            input logic [7:0] wdata,
                                            input logic [7:0] mask);
    applyWrite = (old & ~mask) | (wdata & mask);
  endfunction : applyWrite

  // interval mask from the select code
  function automatic logic [14:0] intervalMask(input logic [1:0] sel);
    unique case (sel)
      2'b00:   intervalMask = lssel_pkg::IVL_MASK_0;
      2'b01:   intervalMask = lssel_pkg::IVL_MASK_1;
      2'b10:   intervalMask = lssel_pkg::IVL_MASK_2;
      2'b11:   intervalMask = lssel_pkg::IVL_MASK_1S;
    endcase
  endfunction : intervalMask

  // registers
  logic [7:0]            xtalGate_q;
  logic [7:0]            xtalTrim_q;
  logic [7:0]            oscCtrl0_q;
  logic [7:0]            oscCtrl2_q;
  logic [7:0]            slowTrim_q;
  logic                  present_q;
  logic                  written_q;
  logic                  lowPower_q;
  logic                  bootDone_q;
  logic [7:0]            rdData_q;

  // 32 kHz domain state
  logic [14:0]           sleepCnt_q;
  logic                  clk32Sel_q;
  logic                  ivlEdge_q;

  // registered outputs
  logic                  hsEnable_q;
  logic                  extClk_q;
  lssel_pkg::lssel_slow_t slowOut_q;
  lssel_pkg::lssel_xtal_t xtalOut_q;
  lssel_pkg::lssel_xpwr_t pwrState_q;
  lssel_pkg::lssel_xpwr_t pwrState_d;

  // synchronised inputs
  logic                  debugLevel;
  logic                  slowRise;
  logic                  xtalRise;

  // decode and derived terms
  logic                  wrGate;
  logic                  wrTrim;
  logic                  wrCtrl0;
  logic                  wrCfg;
  logic                  wrCtrl2;
  logic                  wrSlow;
  logic                  wdtClear;
  logic [7:0]            rdMux;
  logic [7:0]            cfgRead;
  logic                  gateAllow;
  logic                  xtalOn;
  logic                  tick32;
  logic [14:0]           sleepInc;
  logic                  ivlHit;
  logic [7:0]            slowTrimBoot;

  // resync to system clock
  // debug pin and both oscillator clocks pass three stages on whatever drives clk
  lssel_sync3 u_sync_debug
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn (onChipDebugMode),
    .level   (debugLevel),
    .rise    ()
  );

  lssel_sync3 u_sync_slow
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn (slowOscClk),
    .level   (),
    .rise    (slowRise)
  );

  lssel_sync3 u_sync_xtal
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn (crystalClk),
    .level   (),
    .rise    (xtalRise)
  );

  // write decode
  assign wrGate  = regWrite && (regAddr == lssel_pkg::OFF_XTAL_GATE);
  assign wrTrim  = regWrite && (regAddr == lssel_pkg::OFF_XTAL_TRIM);
  assign wrCtrl0 = regWrite && (regAddr == lssel_pkg::OFF_OSC_CTRL0);
  assign wrCfg   = regWrite && (regAddr == lssel_pkg::OFF_XTAL_CFG);
  assign wrCtrl2 = regWrite && (regAddr == lssel_pkg::OFF_OSC_CTRL2);
  assign wrSlow  = regWrite && (regAddr == lssel_pkg::OFF_SLOW_TRIM);

  assign wdtClear = regWrite && (regAddr == lssel_pkg::OFF_WDT_RESTART)
                    && (regWrData == lssel_pkg::WDT_CLEAR_KEY);

  // configuration read image; upper bits read zero
  assign cfgRead = {5'h00, lowPower_q, written_q, present_q};

  // read selection, unmapped reads zero
  assign rdMux =
    (regAddr == lssel_pkg::OFF_XTAL_GATE) ? xtalGate_q :
    (regAddr == lssel_pkg::OFF_XTAL_TRIM) ? xtalTrim_q :
    (regAddr == lssel_pkg::OFF_OSC_CTRL0) ? oscCtrl0_q :
    (regAddr == lssel_pkg::OFF_XTAL_CFG)  ? cfgRead    :
    (regAddr == lssel_pkg::OFF_OSC_CTRL2) ? oscCtrl2_q :
    (regAddr == lssel_pkg::OFF_SLOW_TRIM) ? slowTrim_q :
    lssel_pkg::ZERO_BYTE;

  // only code 011b lets the crystal run
  assign gateAllow = (xtalGate_q[lssel_pkg::GATE_MSB:0] == lssel_pkg::GATE_ALLOW);
  assign xtalOn    = gateAllow && oscCtrl0_q[lssel_pkg::BIT_XTAL_REQ];

  // sleep timer counts ticks of the selected 32 kHz source
  assign tick32   = clk32Sel_q ? xtalRise : slowRise;
  assign sleepInc = 15'(sleepCnt_q + 15'h0001);

  // interval edge needs no interrupt enable
  assign ivlHit = tick32
                  && ((sleepInc & intervalMask(oscCtrl0_q[lssel_pkg::IVL_MSB:lssel_pkg::IVL_LSB]))
                      == 15'h0000);

  // factory trim replaces the trim field at boot
  assign slowTrimBoot = {slowTrim_q[7:lssel_pkg::TRIM_MSB + 1], factoryTrim};

  // plain control registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xtalGate_q <= lssel_pkg::RST_XTAL_GATE;
      xtalTrim_q <= lssel_pkg::RST_XTAL_TRIM;
      oscCtrl0_q <= lssel_pkg::RST_OSC_CTRL0;
      oscCtrl2_q <= lssel_pkg::RST_OSC_CTRL2;
    end
    else
    begin
      if (wrGate)
        xtalGate_q <= applyWrite(xtalGate_q, regWrData, lssel_pkg::MSK_XTAL_GATE);
      if (wrTrim)
        xtalTrim_q <= applyWrite(xtalTrim_q, regWrData, lssel_pkg::MSK_XTAL_TRIM);
      if (wrCtrl0)
        oscCtrl0_q <= applyWrite(oscCtrl0_q, regWrData, lssel_pkg::MSK_OSC_CTRL0);
      if (wrCtrl2)
        oscCtrl2_q <= applyWrite(oscCtrl2_q, regWrData, lssel_pkg::MSK_OSC_CTRL2);
    end
  end

  // slow oscillator trim register with boot load
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slowTrim_q <= lssel_pkg::RST_SLOW_TRIM;
      bootDone_q <= 1'b0;
    end
    else if (!bootDone_q)
    begin
      // boot load wins over a write
      slowTrim_q <= slowTrimBoot;
      bootDone_q <= 1'b1;
    end
    else if (wrSlow)
    begin
      slowTrim_q <= applyWrite(slowTrim_q, regWrData, lssel_pkg::MSK_SLOW_TRIM);
    end
  end

  // crystal configuration with write-once present flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      present_q  <= 1'b0;
      written_q  <= 1'b0;
      lowPower_q <= 1'b0;
    end
    else if (wrCfg)
    begin
      lowPower_q <= regWrData[lssel_pkg::BIT_LOW_PWR];
      if (!written_q)
        present_q <= regWrData[lssel_pkg::BIT_PRESENT];
      written_q <= 1'b1;
    end
  end

  // sleep timer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sleepCnt_q <= 15'h0000;
    else if (wdtClear)
      sleepCnt_q <= 15'h0000;
    else if (tick32)
      sleepCnt_q <= sleepInc;
  end

  // 32 kHz source select
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      clk32Sel_q <= 1'b0;
    else if (!xtalOn)
      clk32Sel_q <= 1'b0;
    // switch on interval edge if present
    else if (ivlHit && present_q)
      clk32Sel_q <= 1'b1;
  end

  // interval edge pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ivlEdge_q <= 1'b0;
    else
      ivlEdge_q <= ivlHit;
  end

  // crystal power state from enable, select and low-power bit
  always_comb
  begin
    if (!xtalOn)
      pwrState_d = lssel_pkg::XPWR_DOWN;
    else if (!clk32Sel_q)
      pwrState_d = lssel_pkg::XPWR_STARTUP;
    else if (lowPower_q)
      pwrState_d = lssel_pkg::XPWR_LOW;
    else
      pwrState_d = lssel_pkg::XPWR_HIGH;
  end

  // output register stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hsEnable_q <= 1'b0;
      extClk_q   <= 1'b0;
      slowOut_q  <= '0;
      xtalOut_q  <= '0;
      pwrState_q <= lssel_pkg::XPWR_DOWN;
    end
    else
    begin
      // debug mode forces the 48 MHz clock
      hsEnable_q <= oscCtrl2_q[lssel_pkg::BIT_HS_EN] | debugLevel;
      extClk_q <= oscCtrl2_q[lssel_pkg::BIT_EXT_CLK];
      slowOut_q.enable <= ~clk32Sel_q;
      slowOut_q.powerdownStyle <= slowTrim_q[lssel_pkg::BIT_PD_STYLE];
      slowOut_q.rateSelect <= slowTrim_q[lssel_pkg::BIT_RATE];
      slowOut_q.trim <= slowTrim_q[lssel_pkg::TRIM_MSB:lssel_pkg::TRIM_LSB];
      xtalOut_q.enable <= xtalOn;
      xtalOut_q.ampGain <= xtalTrim_q[lssel_pkg::GAIN_MSB:lssel_pkg::GAIN_LSB];
      xtalOut_q.gainMode <= xtalTrim_q[lssel_pkg::MODE_MSB:lssel_pkg::MODE_LSB];
      xtalOut_q.lowPowerEnable <= lowPower_q;
      pwrState_q <= pwrState_d;
    end
  end

  // read data valid the cycle after the read strobe only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdData_q <= lssel_pkg::ZERO_BYTE;
    else
      rdData_q <= regRead ? rdMux : lssel_pkg::ZERO_BYTE;
  end

  // outputs
  assign regRdData            = rdData_q;
  assign highSpeedClockEnable = hsEnable_q;
  assign externalClockSelect  = extClk_q;
  assign slowOsc              = slowOut_q;
  assign crystalOsc           = xtalOut_q;
  assign crystalPowerState    = pwrState_q;
  assign clk32Select          = clk32Sel_q;
  assign sleepIntervalEdge    = ivlEdge_q;

endmodule : lssel_clock_source

// File: tb/lssel_clock_source_monitor.sv
// lssel_clock_source_monitor: port assertions for the clock source block
`timescale 1ns/1ps
module lssel_clock_source_monitor
(
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // register port
  input wire logic [7:0]             regAddr,
  input wire logic [7:0]             regWrData,
  input wire logic                   regWrite,
  input wire logic                   regRead,
  input wire logic [7:0]             regRdData,
  // pins and oscillator clocks
  input wire logic [3:0]             factoryTrim,
  input wire logic                   onChipDebugMode,
  input wire logic                   slowOscClk,
  input wire logic                   crystalClk,
  // controls and status
  input wire logic                   highSpeedClockEnable,
  input wire logic                   externalClockSelect,
  input wire lssel_pkg::lssel_slow_t slowOsc,
  input wire lssel_pkg::lssel_xtal_t crystalOsc,
  input wire lssel_pkg::lssel_xpwr_t crystalPowerState,
  input wire logic                   clk32Select,
  input wire logic                   sleepIntervalEdge
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // write data two edges back, lines up with the output stage
  logic [7:0] wd1_q;
  logic [7:0] wd2_q;
  always_ff @(posedge clk)
  begin
    wd1_q <= regWrData;
    wd2_q <= wd1_q;
  end

  a_debug_forces:
    assert property (onChipDebugMode [*8] |-> highSpeedClockEnable)
    else $error("fast clock off in debug mode");
  a_extclk_follows:
    assert property (regWrite && regAddr == lssel_pkg::OFF_OSC_CTRL2
      |-> ##2 externalClockSelect == wd2_q[2])
    else $error("external clock select not following write");
  a_gain_follows:
    assert property (regWrite && regAddr == lssel_pkg::OFF_XTAL_TRIM
      |-> ##2 crystalOsc.ampGain == wd2_q[4:2])
    else $error("amplifier gain not following write");
  a_switch_on_edge:
    assert property ($rose(clk32Select) |-> sleepIntervalEdge)
    else $error("crystal switch away from interval edge");
  a_fall_back:
    assert property ($fell(crystalOsc.enable) |-> ##[0:2] !clk32Select)
    else $error("no return to slow oscillator");
  a_slow_runs:
    assert property (!clk32Select [*6] |-> slowOsc.enable)
    else $error("slow oscillator stopped before switch");
  a_written_bit:
    assert property (regWrite && regAddr == lssel_pkg::OFF_XTAL_CFG ##[1:2]
      regRead && regAddr == lssel_pkg::OFF_XTAL_CFG |=> regRdData[1])
    else $error("written bit clear after config write");
  a_power_switched:
    assert property (clk32Select && $past(clk32Select) |-> crystalPowerState
      inside {lssel_pkg::XPWR_HIGH, lssel_pkg::XPWR_LOW})
    else $error("crystal not in a running power state");
endmodule : lssel_clock_source_monitor

bind lssel_clock_source lssel_clock_source_monitor u_mon (
  .clk, .rst_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .factoryTrim,
  .onChipDebugMode, .slowOscClk, .crystalClk, .highSpeedClockEnable,
  .externalClockSelect, .slowOsc, .crystalOsc, .crystalPowerState, .clk32Select,
  .sleepIntervalEdge
);

// File: tb/lssel_osc_model.sv
// lssel_osc_model: behavioural slow oscillator and watch crystal
`timescale 1ns/1ps
module lssel_osc_model
#(
  parameter int SLOW_HALF = 163,
  parameter int XTAL_HALF = 172
)
(
  // oscillator controls
  input wire logic slowEn,
  input wire logic slowRate,
  input wire logic xtalEn,
  // oscillator clocks
  output logic     slowOscClk,
  output logic     crystalClk
);
  // both clocks start low
  initial slowOscClk = 1'b0;
  initial crystalClk = 1'b0;

  always
  begin
    if (slowEn === 1'b1)
      #(slowRate ? 4 * SLOW_HALF : SLOW_HALF) slowOscClk = ~slowOscClk;
    else
      @(slowEn);
  end

  always
  begin
    if (xtalEn === 1'b1)
      #(XTAL_HALF) crystalClk = ~crystalClk;
    else
      @(xtalEn);
  end
endmodule : lssel_osc_model

// File: tb/tb_low_speed_clock_source_select.sv
// tb_low_speed_clock_source_select: self-checking bench for the clock source block
`timescale 1ns/1ps
module tb_low_speed_clock_source_select;
  // design ports
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic [7:0]             regAddr = 8'h00;
  logic [7:0]             regWrData = 8'h00;
  logic                   regWrite = 1'b0;
  logic                   regRead = 1'b0;
  logic [7:0]             regRdData;
  logic [3:0]             factoryTrim = 4'h0;
  logic                   onChipDebugMode = 1'b0;
  logic                   slowOscClk;
  logic                   crystalClk;
  logic                   highSpeedClockEnable;
  logic                   externalClockSelect;
  lssel_pkg::lssel_slow_t slowOsc;
  lssel_pkg::lssel_xtal_t crystalOsc;
  lssel_pkg::lssel_xpwr_t crystalPowerState;
  logic                   clk32Select;
  logic                   sleepIntervalEdge;
  // bookkeeping and tables of plain registers
  int                     failCount = 0;
  int                     comparisons = 0;
  int                     seed = 32'hec08168f;
  int                     n;
  int                     i;
  logic [7:0]             d;
  logic [3:0]             fTrim;
  logic [7:0]             adr [5] = '{8'hd2, 8'hd3, 8'he0, 8'he2, 8'he9};
  logic [7:0]             msk [5] = '{8'h07, 8'h1f, 8'h98, 8'h14, 8'h6f};
  logic [7:0]             rstv [5] = '{8'h07, 8'h14, 8'h00, 8'h00, 8'h00};

  // 25 MHz clock
  always #20 clk = ~clk;

  lssel_clock_source DUT (
    .clk, .rst_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .factoryTrim,
    .onChipDebugMode, .slowOscClk, .crystalClk, .highSpeedClockEnable,
    .externalClockSelect, .slowOsc, .crystalOsc, .crystalPowerState, .clk32Select,
    .sleepIntervalEdge
  );

  lssel_osc_model u_osc (
    .slowEn(slowOsc.enable), .slowRate(slowOsc.rateSelect), .xtalEn(crystalOsc.enable),
    .slowOscClk, .crystalClk
  );

  // read-back value of a plain register
  function automatic logic [7:0] expRd(input int k, input logic [7:0] v);
    expRd = (v & msk[k]) | ((k == 4) ? 8'h10 : 8'h00);
  endfunction : expRd

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failCount++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    check(regRdData, e);
  endtask : rd

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : settle

  task automatic resetDut;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    settle(2);
  endtask : resetDut

  // bounded wait for the sleep interval pulse, n counts cycles
  task automatic waitEdge(input int lim);
    n = 0;
    while (sleepIntervalEdge !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim)
      begin
        failCount++;
        reportAndStop();
      end
    end
  endtask : waitEdge

  task automatic reportAndStop;
    $display("comparisons %0d, mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : reportAndStop

  // main sequence
  initial
  begin
    fTrim = 4'($random(seed));
    @(posedge clk);
    factoryTrim <= fTrim;
    resetDut();
    for (i = 0; i < 5; i++)
      rd(adr[i], expRd(i, (i == 4) ? {4'h0, fTrim} : rstv[i]));
    rd(8'he1, 8'h00);
    check({7'h0, clk32Select}, 8'h00);
    wr(8'he5, 8'hff);
    rd(8'he5, 8'h00);
    rd(8'he3, 8'h00);
    $display("reset values done");
    // crystal absent: flag locked at zero, switch blocked
    wr(8'he1, 8'h00);
    rd(8'he1, 8'h02);
    wr(8'he1, 8'h01);
    rd(8'he1, 8'h02);
    wr(8'hd2, 8'h03);
    wr(8'he0, 8'h80);
    wr(8'he3, 8'h38);
    waitEdge(600);
    check({7'h0, n > 505 && n < 540}, 8'h01);
    check({6'h0, crystalOsc.enable, clk32Select}, 8'h02);
    $display("blocked switch done");
    // plain registers: all ones first, then random
    for (int k = 0; k < 20; k++)
    begin
      i = (k < 5) ? k : {$random(seed)} % 5;
      d = (k < 5) ? 8'hff : 8'($random(seed));
      // reserved bit of control two written as zero
      if (i == 3)
        d[1] = 1'b0;
      // factory trim field left as loaded
      if (i == 4)
        d[3:0] = fTrim;
      wr(adr[i], d);
      settle(1);
      case (i)
        1: check({3'h0, crystalOsc[5:1]}, {3'h0, d[4:0]});
        3: check({6'h0, highSpeedClockEnable, externalClockSelect}, {6'h0, d[4], d[2]});
        4: check({2'h0, slowOsc[5:0]}, {2'h0, d[6:5], d[3:0]});
        default: ;
      endcase
      rd(adr[i], expRd(i, d));
    end
    wr(8'he2, 8'h00);
    onChipDebugMode <= 1'b1;
    settle(10);
    check({7'h0, highSpeedClockEnable}, 8'h01);
    @(posedge clk);
    onChipDebugMode <= 1'b0;
    $display("register fields done");
    // crystal present: timed switch, low power, return, reserved gate code
    resetDut();
    check({7'h0, clk32Select}, 8'h00);
    wr(8'he1, 8'h01);
    rd(8'he1, 8'h03);
    // bring-up order: present flag, gate, interval, then enable
    wr(8'hd2, 8'h03);
    wr(8'he0, 8'h00);
    wr(8'he0, 8'h80);
    wr(8'he3, 8'h38);
    settle(1);
    check({5'h0, crystalOsc.enable, clk32Select, slowOsc.enable}, 8'h05);
    check({6'h0, crystalPowerState}, 8'h01);
    waitEdge(600);
    check({7'h0, clk32Select}, 8'h01);
    settle(3);
    check({5'h0, crystalOsc.enable, clk32Select, slowOsc.enable}, 8'h06);
    check({6'h0, crystalPowerState}, 8'h02);
    wr(8'he1, 8'h04);
    rd(8'he1, 8'h07);
    check({6'h0, crystalPowerState}, 8'h03);
    check({7'h0, crystalOsc.lowPowerEnable}, 8'h01);
    wr(8'he0, 8'h00);
    settle(3);
    check({5'h0, crystalOsc.enable, clk32Select, slowOsc.enable}, 8'h01);
    check({6'h0, crystalPowerState}, 8'h00);
    wr(8'he0, 8'h80);
    wr(8'hd2, 8'h05);
    settle(1);
    check({7'h0, crystalOsc.enable}, 8'h00);
    $display("crystal switch done");
    reportAndStop();
  end
endmodule : tb_low_speed_clock_source_select
